// *** common/smta_pkg.sv ***
package smta_pkg;

  // system clock rate
  localparam int CLK_KHZ = 20000;

  // bus timing, all in microseconds
  localparam int TIMEOUT_MIN_US = 25000;  // clock low longer than this is a timeout
  localparam int TIMEOUT_MAX_US = 35000;  // interface must be reset by then
  localparam int SEXT_MAX_US = 25000;     // cumulative target stretch per message
  localparam int HIGH_MAX_US = 50;        // clock high beyond this means bus idle
  localparam int STRAP_SETTLE_US = 10;    // strap pull settling per probe phase

  // derived cycle counts: least times round up, longest round down
  localparam int TIMEOUT_CYC = (TIMEOUT_MIN_US * CLK_KHZ + 999) / 1000;
  localparam int TIMEOUT_MAX_CYC = TIMEOUT_MAX_US * CLK_KHZ / 1000;
  localparam int SEXT_CYC = SEXT_MAX_US * CLK_KHZ / 1000;
  localparam int HIGH_MAX_CYC = HIGH_MAX_US * CLK_KHZ / 1000;
  localparam int SETTLE_CYC = (STRAP_SETTLE_US * CLK_KHZ + 999) / 1000;

  // byte framing and strap counts
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam int NUM_STRAPS = 3;
  localparam int NUM_STRAP_CODES = 27;

  // sensed strap level
  typedef enum logic [1:0] {
    LVL_OPEN = 2'b00,
    LVL_LOW = 2'b01,
    LVL_HIGH = 2'b10
  } smta_level_type;

  // decoded address per strap code, index = msb*9 + mid*3 + lsb
  localparam logic [6:0] ADDR_TABLE [NUM_STRAP_CODES] = '{
    7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46, 7'h47, 7'h10,
    7'h11, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17, 7'h53, 7'h53,
    7'h53, 7'h53, 7'h54, 7'h56, 7'h56, 7'h57, 7'h58, 7'h59, 7'h5a
  };

  // bus protocol states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_RX = 2'b10,
    ST_TX = 2'b11
  } smta_state_type;

  // strap probe phases
  typedef enum logic [1:0] {
    SP_LOW = 2'b00,
    SP_HIGH = 2'b01,
    SP_LATCH = 2'b10,
    SP_DONE = 2'b11
  } smta_phase_type;

  // strap pins read with pull-down and with pull-up applied
  typedef struct packed {
    logic [NUM_STRAPS-1:0] pulled_lo;
    logic [NUM_STRAPS-1:0] pulled_hi;
  } smta_sample_type;

  // one 12-bit value as it travels, low byte first
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } smta_bytes_type;

  // split a 12-bit value, upper nibble of the second byte zero
  function automatic smta_bytes_type split12(input logic [11:0] value);
    smta_bytes_type b;
    b.lo = value[7:0];
    b.hi = {4'h0, value[11:8]};
    return b;
  endfunction

endpackage

// *** verilog/smta_strap_decode.sv ***
`timescale 1ns/10ps
`default_nettype none
module smta_strap_decode
  import smta_pkg::*;
(
  // probe samples
  input wire smta_sample_type i_sample,
  // decoded levels and address
  output logic [NUM_STRAPS-1:0][1:0] o_levels,
  output logic [6:0] o_addr
);

  logic [4:0] idx;

  ////////////////////////////////////////////////////////////////////////////
  // three-level sense per pin: follows both pulls means open
  for (genvar g = 0; g < NUM_STRAPS; g++) begin : g_pin
    assign o_levels[g] = (!i_sample.pulled_lo[g] && i_sample.pulled_hi[g]) ? LVL_OPEN :
                         (i_sample.pulled_hi[g] ? LVL_HIGH : LVL_LOW);
  end

  ////////////////////////////////////////////////////////////////////////////
  // strap code to 7-bit address
  assign idx = 5'(5'(o_levels[2]) * 5'd9 + 5'(o_levels[1]) * 5'd3 + 5'(o_levels[0]));
  assign o_addr = ADDR_TABLE[idx];

endmodule
`default_nettype wire

// *** verilog/smta_target.sv ***
`timescale 1ns/10ps
`default_nettype none
module smta_target
  import smta_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter int SEXT_CYCLES = SEXT_CYC,
  parameter int HIGH_MAX_CYCLES = HIGH_MAX_CYC,
  parameter int SETTLE_CYCLES = SETTLE_CYC
) (
  // system clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // bus clock pin, also the link capture clock
  input wire logic I_SCL,
  output logic O_SCL,
  output logic O_SCL_OE,
  // bus data pin
  input wire logic I_SDA,
  output logic O_SDA,
  output logic O_SDA_OE,
  // address straps and probe pull select
  input wire logic I_ADDR_STRAP_BIT0,
  input wire logic I_ADDR_STRAP_BIT1,
  input wire logic I_ADDR_STRAP_BIT2,
  output logic O_ADDR_STRAP_PULL_UP,
  // user side
  input wire logic [11:0] I_TX_WORD,
  input wire logic I_HOLD,
  output logic [6:0] O_BUS_ADDR,
  output logic O_ADDR_VALID,
  output logic [7:0] O_RX_DATA,
  output logic O_RX_VALID,
  output logic O_RX_FIRST,
  output logic O_BUSY,
  output logic O_TIMEOUT
);

  localparam int CNT_W = $clog2(TIMEOUT_CYCLES + SEXT_CYCLES + SETTLE_CYCLES + 2);

  logic link_tgl_q = 1'b0;
  logic link_bit_q = 1'b0;
  logic scl_m1, scl_q, scl_p_q, sda_m1, sda_q, sda_p_q;
  logic tgl_m1, tgl_q, tgl_seen_q, bit_m1, bit_q;
  logic [NUM_STRAPS-1:0] strap_m1, strap_q;
  smta_phase_type phase_q;
  smta_sample_type samp_q;
  logic [CNT_W-1:0] settle_q, low_q, high_q, sext_q;
  logic [NUM_STRAPS-1:0][1:0] dec_lvl;
  logic [6:0] dec_addr, addr_q;
  logic addr_ok_q;
  smta_state_type state_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q, tx_byte;
  logic [11:0] tx_word_q;
  logic tx_sel_q, first_q, sda_oe_q, scl_oe_q, tout_q;
  logic bit_ev, start_c, stop_c, scl_fall, match, low_fire, sext_fire, high_fire, abort;
  smta_bytes_type tx_bytes;

  ////////////////////////////////////////////////////////////////////////////
  // link domain: capture data on each bus clock rise, toggle to mark it
  always_ff @(posedge I_SCL) begin
    link_tgl_q <= ~link_tgl_q;
    link_bit_q <= I_SDA;
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers into the system domain
  always_ff @(posedge I_CLK) begin
    scl_m1 <= I_SCL;
    scl_q <= scl_m1;
    sda_m1 <= I_SDA;
    sda_q <= sda_m1;
    tgl_m1 <= link_tgl_q;
    tgl_q <= tgl_m1;
    bit_m1 <= link_bit_q;
    bit_q <= bit_m1;
    strap_m1 <= {I_ADDR_STRAP_BIT2, I_ADDR_STRAP_BIT1, I_ADDR_STRAP_BIT0};
    strap_q <= strap_m1;
  end

  // edge history
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      tgl_seen_q <= tgl_q; // no false bit event after a reset
    end else begin
      scl_p_q <= scl_q;
      sda_p_q <= sda_q;
      tgl_seen_q <= tgl_q;
    end
  end

  // bus events
  assign bit_ev = tgl_q ^ tgl_seen_q;
  assign start_c = scl_q && scl_p_q && sda_p_q && !sda_q;
  assign stop_c = scl_q && scl_p_q && !sda_p_q && sda_q;
  assign scl_fall = scl_p_q && !scl_q;

  ////////////////////////////////////////////////////////////////////////////
  // strap probe: sample under pull-down, then pull-up, then latch once
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      phase_q <= SP_LOW;
      settle_q <= '0;
      samp_q <= '0;
      addr_q <= '0;
      addr_ok_q <= 1'b0;
    end else begin
      unique case (phase_q)
        SP_LOW, SP_HIGH: begin
          if (settle_q == CNT_W'(SETTLE_CYCLES)) begin
            settle_q <= '0;
            if (phase_q == SP_LOW) begin
              samp_q.pulled_lo <= strap_q;
              phase_q <= SP_HIGH;
            end else begin
              samp_q.pulled_hi <= strap_q;
              phase_q <= SP_LATCH;
            end
          end else begin
            settle_q <= settle_q + 1'b1;
          end
        end
        SP_LATCH: begin
          addr_q <= dec_addr;
          addr_ok_q <= 1'b1;
          phase_q <= SP_DONE;
        end
        SP_DONE: begin
          phase_q <= SP_DONE;
        end
      endcase
    end
  end

  smta_strap_decode u_decode (
    .i_sample(samp_q),
    .o_levels(dec_lvl),
    .o_addr(dec_addr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // timeout counters
  assign low_fire = (low_q == CNT_W'(TIMEOUT_CYCLES));
  assign sext_fire = (sext_q == CNT_W'(SEXT_CYCLES));
  assign high_fire = (high_q == CNT_W'(HIGH_MAX_CYCLES));
  assign abort = low_fire || sext_fire || high_fire;

  // clock-low and clock-high time, held at zero while idle
  always_ff @(posedge I_CLK) begin
    if (I_RST || state_q == ST_IDLE || abort) begin
      low_q <= '0;
      high_q <= '0;
    end else begin
      low_q <= scl_q ? '0 : low_q + 1'b1;
      high_q <= scl_q ? high_q + 1'b1 : '0;
    end
  end

  // stretch time summed from start to stop
  always_ff @(posedge I_CLK) begin
    if (I_RST || start_c || stop_c || abort) begin
      sext_q <= '0;
    end else if (scl_oe_q) begin
      sext_q <= sext_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // protocol state
  assign match = (shift_q[7:1] == addr_q);

  always_ff @(posedge I_CLK) begin
    if (I_RST || abort || stop_c) begin
      state_q <= ST_IDLE;
    end else if (start_c) begin
      state_q <= addr_ok_q ? ST_ADDR : ST_IDLE;
    end else if (bit_ev && cnt_q == ACK_SLOT) begin
      unique case (state_q)
        ST_ADDR: state_q <= !match ? ST_IDLE : (shift_q[0] ? ST_TX : ST_RX);
        ST_TX: state_q <= bit_q ? ST_IDLE : ST_TX;
        default: state_q <= state_q;
      endcase
    end
  end

  // bit counter and receive shift register
  always_ff @(posedge I_CLK) begin
    if (I_RST || start_c) begin
      cnt_q <= '0;
      shift_q <= '0;
    end else if (bit_ev) begin
      if (cnt_q == ACK_SLOT) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
        shift_q <= {shift_q[6:0], bit_q};
      end
    end
  end

  // received bytes to the user
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_RX_DATA <= '0;
      O_RX_VALID <= 1'b0;
      O_RX_FIRST <= 1'b0;
      first_q <= 1'b0;
    end else begin
      O_RX_VALID <= 1'b0;
      if (bit_ev && cnt_q == ACK_SLOT && state_q == ST_ADDR) begin
        first_q <= 1'b1;
      end else if (bit_ev && cnt_q == ACK_SLOT && state_q == ST_RX) begin
        O_RX_DATA <= shift_q;
        O_RX_VALID <= 1'b1;
        O_RX_FIRST <= first_q;
        first_q <= 1'b0;
      end
    end
  end

  // transmit word, low byte then high byte
  always_ff @(posedge I_CLK) begin
    if (I_RST || start_c) begin
      tx_sel_q <= 1'b0;
      tx_word_q <= '0;
    end else if (bit_ev && cnt_q == ACK_SLOT) begin
      if (state_q == ST_ADDR) begin
        tx_word_q <= I_TX_WORD;
      end else if (state_q == ST_TX && !bit_q) begin
        tx_sel_q <= ~tx_sel_q;
        if (tx_sel_q) begin
          tx_word_q <= I_TX_WORD;
        end
      end
    end
  end

  assign tx_bytes = split12(tx_word_q);
  assign tx_byte = tx_sel_q ? tx_bytes.hi : tx_bytes.lo;

  ////////////////////////////////////////////////////////////////////////////
  // data line drive, updated on a clock fall, cleared on abort, start or stop
  always_ff @(posedge I_CLK) begin
    if (I_RST || abort || stop_c || start_c) begin
      sda_oe_q <= 1'b0;
    end else if (scl_fall) begin
      if (cnt_q == ACK_SLOT) begin
        sda_oe_q <= (state_q == ST_ADDR && match) || state_q == ST_RX;
      end else begin
        sda_oe_q <= (state_q == ST_TX) && !tx_byte[3'(4'd7 - cnt_q)];
      end
    end
  end

  // clock stretch while the user is busy at a byte boundary
  always_ff @(posedge I_CLK) begin
    if (I_RST || abort || !I_HOLD || state_q == ST_IDLE) begin
      scl_oe_q <= 1'b0;
    end else if (scl_fall && cnt_q == 4'h0 && (state_q == ST_RX || state_q == ST_TX)) begin
      scl_oe_q <= 1'b1;
    end
  end

  // timeout report
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      tout_q <= 1'b0;
    end else begin
      tout_q <= low_fire || sext_fire;
    end
  end

  assign O_SCL = 1'b0;
  assign O_SDA = 1'b0;
  assign O_SCL_OE = scl_oe_q;
  assign O_SDA_OE = sda_oe_q;
  assign O_ADDR_STRAP_PULL_UP = (phase_q == SP_HIGH);
  assign O_BUS_ADDR = addr_q;
  assign O_ADDR_VALID = addr_ok_q;
  assign O_BUSY = (state_q != ST_IDLE);
  assign O_TIMEOUT = tout_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  a_strap_open_sense: assert property (
    phase_q == SP_LATCH && !samp_q.pulled_lo[0] && samp_q.pulled_hi[0]
    |-> dec_lvl[0] == LVL_OPEN) else $error("open strap not sensed as open");
  a_decode_open_msb: assert property (
    phase_q == SP_LATCH && dec_lvl == {LVL_OPEN, LVL_HIGH, LVL_HIGH}
    |=> addr_q == 7'h10 && addr_ok_q) else $error("open msb high-high not 10h");
  a_decode_low_msb: assert property (
    phase_q == SP_LATCH && dec_lvl == {LVL_LOW, LVL_HIGH, LVL_LOW}
    |=> addr_q == 7'h53) else $error("low msb high-low not 53h");
  a_decode_high_msb: assert property (
    phase_q == SP_LATCH && dec_lvl == {LVL_HIGH, LVL_LOW, LVL_OPEN}
    |=> addr_q == 7'h56) else $error("high msb low-open not 56h");
  a_addr_latch_once: assert property (
    addr_ok_q && $past(addr_ok_q) |-> $stable(addr_q)) else $error("address changed");
  a_addr_compare: assert property (
    bit_ev && cnt_q == ACK_SLOT && state_q == ST_ADDR && !start_c && !stop_c && !abort
    |=> (state_q != ST_IDLE) == (shift_q[7:1] == addr_q)) else $error("address compare");
  a_low_timeout: assert property (
    low_fire |=> state_q == ST_IDLE && !O_SDA_OE && !O_SCL_OE && O_TIMEOUT ##1 !O_TIMEOUT)
    else $error("clock low timeout not handled");
  a_stretch_limit: assert property (
    sext_fire |=> !O_SCL_OE && state_q == ST_IDLE && O_TIMEOUT) else $error("stretch cap");
  a_high_idle: assert property (
    high_fire |=> state_q == ST_IDLE && !O_SDA_OE) else $error("idle not detected");
  a_tx_upper_zero: assert property (
    scl_fall && state_q == ST_TX && tx_sel_q && cnt_q < 4'h4 && !abort && !stop_c
    |=> O_SDA_OE) else $error("upper nibble not zero");

  c_addr_ack: cover property (bit_ev && cnt_q == ACK_SLOT && state_q == ST_ADDR && match);
  c_rx_byte: cover property (O_RX_VALID);
  c_tx_word: cover property (state_q == ST_TX && tx_sel_q);
  c_timeout: cover property (O_TIMEOUT);

endmodule
`default_nettype wire

// *** test/smta_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module smta_host (
  // resolved bus lines
  input wire logic i_scl,
  input wire logic i_sda,
  // open-drain pulls, high = line driven low
  output logic o_scl_oe,
  output logic o_sda_oe
);
  logic tick = 1'b0;
  ////////////////////////////////////////////////////////////////////////
  // 30 ns link base, unrelated to the system clock
  always #15 tick = ~tick;
  initial begin
    o_scl_oe = 1'b0;
    o_sda_oe = 1'b0;
  end
  // half bit: 20 ticks, 12 system cycles
  task automatic half();
    repeat (20) @(posedge tick);
  endtask
  // one bit; low phase fixed, far below the per-message extension cap
  task automatic bit_io(input logic b, output logic r);
    o_sda_oe <= !b;
    half();
    o_scl_oe <= 1'b0;
    // clock sync: wait out target stretching, bounded
    for (int k = 0; k < 2000 && i_scl !== 1'b1; k++) @(posedge tick);
    half();
    r = i_sda;
    o_scl_oe <= 1'b1;
    @(posedge tick);
  endtask
  // start from idle
  task automatic start_c();
    o_sda_oe <= 1'b1;
    half();
    o_scl_oe <= 1'b1;
    @(posedge tick);
  endtask
  // stop after a clock low phase
  task automatic stop_c();
    o_sda_oe <= 1'b1;
    half();
    o_scl_oe <= 1'b0;
    half();
    o_sda_oe <= 1'b0;
    half();
  endtask
  // address or data byte out, msb first, returns ack
  task automatic byte_wr(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // byte in, then ack (more) or nack
  task automatic byte_rd(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++) begin
      bit_io(1'b1, r);
      d = {d[6:0], r};
    end
    bit_io(!more, r);
  endtask
  // let the target drop its ack, then release both lines
  task automatic free();
    half();
    o_scl_oe <= 1'b0;
    o_sda_oe <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** test/smta_target_test.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_total++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module smta_target_test;
  localparam int TO = 400;
  localparam int SX = 300;
  localparam int HM = 200;
  localparam logic [6:0] ADR = 7'h5a;
  localparam logic [6:0] EXP [27] = '{7'h40, 7'h41, 7'h42, 7'h43, 7'h44,
    7'h45, 7'h46, 7'h47, 7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16,
    7'h17, 7'h53, 7'h53, 7'h53, 7'h53, 7'h54, 7'h56, 7'h56, 7'h57, 7'h58,
    7'h59, 7'h5a};
  logic I_CLK = 1'b0;
  logic I_RST = 1'b1;
  logic I_HOLD = 1'b0;
  logic [11:0] I_TX_WORD = 12'h000;
  logic [1:0] lv [3];
  logic [2:0] strap;
  logic scl, sda, h_scl, h_sda, d_scl, d_sda, pull_up, addr_ok, busy;
  logic rx_v, rx_f, to_p, rx_first, ack;
  logic [6:0] addr;
  logic [7:0] rx_d, rx_last, rx_head, d;
  int rx_cnt = 0;
  int to_cnt = 0;
  int cyc = 0;
  int n;
  int err_total = 0;
  int n_checks = 0;
  ////////////////////////////////////////////////////////////////////////
  // open pin follows the probe pull, tied pins their level
  assign strap[0] = (lv[0] == 2'd0) ? pull_up : (lv[0] == 2'd2);
  assign strap[1] = (lv[1] == 2'd0) ? pull_up : (lv[1] == 2'd2);
  assign strap[2] = (lv[2] == 2'd0) ? pull_up : (lv[2] == 2'd2);
  // open-drain wires with pull-ups
  assign scl = !(h_scl || d_scl);
  assign sda = !(h_sda || d_sda);
  always #25 I_CLK = ~I_CLK;
  smta_target #(.TIMEOUT_CYCLES(TO), .SEXT_CYCLES(SX), .HIGH_MAX_CYCLES(HM),
    .SETTLE_CYCLES(4)) i_dut (.I_CLK(I_CLK), .I_RST(I_RST), .I_SCL(scl),
    .O_SCL(), .O_SCL_OE(d_scl), .I_SDA(sda), .O_SDA(), .O_SDA_OE(d_sda),
    .I_ADDR_STRAP_BIT0(strap[0]), .I_ADDR_STRAP_BIT1(strap[1]),
    .I_ADDR_STRAP_BIT2(strap[2]), .O_ADDR_STRAP_PULL_UP(pull_up),
    .I_TX_WORD(I_TX_WORD), .I_HOLD(I_HOLD), .O_BUS_ADDR(addr),
    .O_ADDR_VALID(addr_ok), .O_RX_DATA(rx_d), .O_RX_VALID(rx_v),
    .O_RX_FIRST(rx_f), .O_BUSY(busy), .O_TIMEOUT(to_p));
  smta_host i_host (.i_scl(scl), .i_sda(sda), .o_scl_oe(h_scl),
    .o_sda_oe(h_sda));
  ////////////////////////////////////////////////////////////////////////
  // pulse monitors and hang limit
  always @(posedge I_CLK) begin
    cyc <= cyc + 1;
    if (rx_v === 1'b1) begin
      rx_last <= rx_d;
      rx_first <= rx_f;
      rx_cnt <= rx_cnt + 1;
      if (rx_f === 1'b1) rx_head <= rx_d;
    end
    if (to_p === 1'b1) to_cnt <= to_cnt + 1;
    if (cyc == 60000) begin
      err_total++;
      summarize();
    end
  end
  task automatic cyc_n(input int k);
    repeat (k) @(posedge I_CLK);
  endtask
  task automatic do_reset(input int c);
    @(posedge I_CLK);
    I_RST <= 1'b1;
    lv[2] <= 2'(c / 9);
    lv[1] <= 2'((c / 3) % 3);
    lv[0] <= 2'(c % 3);
    cyc_n(10);
    `CHK(addr_ok, 1'b0)
    I_RST <= 1'b0;
    for (int k = 0; k < 100 && addr_ok !== 1'b1; k++) @(posedge I_CLK);
  endtask
  // all strap codes, then straps moved after the latch
  task automatic t_straps();
    for (int c = 0; c < 27; c++) begin
      do_reset(c);
      `CHK(addr, EXP[c])
    end
    lv[1] <= 2'd1;
    cyc_n(20);
    `CHK(addr, ADR)
    lv[1] <= 2'd2;
  endtask
  // two bytes back to back, then a foreign address
  task automatic t_write();
    n = rx_cnt;
    i_host.start_c();
    i_host.byte_wr({ADR, 1'b0}, ack);
    `CHK(ack, 1'b1)
    i_host.byte_wr(8'h3c, ack);
    i_host.byte_wr(8'h05, ack);
    i_host.stop_c();
    `CHK(rx_cnt - n, 2)
    `CHK(rx_head, 8'h3c)
    `CHK(rx_last, 8'h05)
    `CHK(rx_first, 1'b0)
    `CHK(busy, 1'b0)
    i_host.start_c();
    i_host.byte_wr({7'h5b, 1'b0}, ack);
    `CHK(ack, 1'b0)
    i_host.stop_c();
  endtask
  // word read low byte first
  task automatic t_read();
    @(posedge I_CLK);
    I_TX_WORD <= 12'h9a5;
    i_host.start_c();
    i_host.byte_wr({ADR, 1'b1}, ack);
    `CHK(ack, 1'b1)
    i_host.byte_rd(1'b1, d);
    `CHK(d, 8'ha5)
    i_host.byte_rd(1'b0, d);
    `CHK(d, 8'h09)
    i_host.stop_c();
  endtask
  // host parks the clock low past the timeout
  task automatic t_timeout();
    n = to_cnt;
    i_host.start_c();
    i_host.byte_wr({ADR, 1'b0}, ack);
    cyc_n(TO - 30);
    `CHK(to_cnt - n, 0)
    for (int k = 0; k < 100 && to_cnt == n; k++) @(posedge I_CLK);
    `CHK(to_cnt - n, 1)
    `CHK(busy, 1'b0)
    i_host.stop_c();
  endtask
  // user hold: target stretches from the fall after the address ack until its cap
  task automatic t_stretch();
    @(posedge I_CLK);
    I_HOLD <= 1'b1;
    n = to_cnt;
    i_host.start_c();
    i_host.byte_wr({ADR, 1'b0}, ack);
    `CHK(ack, 1'b1)
    for (int k = 0; k < 40 && d_scl !== 1'b1; k++) @(posedge I_CLK);
    cyc_n(SX - 60);
    `CHK(d_scl, 1'b1)
    for (int k = 0; k < 150 && d_scl === 1'b1; k++) @(posedge I_CLK);
    cyc_n(4);
    `CHK(to_cnt - n, 1)
    `CHK(d_scl | d_sda, 1'b0)
    I_HOLD <= 1'b0;
    i_host.stop_c();
  endtask
  // clock left high: bus seen idle, no timeout pulse
  task automatic t_idle();
    n = to_cnt;
    i_host.start_c();
    i_host.byte_wr({ADR, 1'b0}, ack);
    i_host.free();
    cyc_n(HM - 40);
    `CHK(busy, 1'b1)
    cyc_n(80);
    `CHK(busy, 1'b0)
    `CHK(to_cnt - n, 0)
  endtask
  task automatic summarize();
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    lv[0] = 2'd0;
    lv[1] = 2'd0;
    lv[2] = 2'd0;
    t_straps();
    t_write();
    t_read();
    t_timeout();
    t_stretch();
    t_idle();
    summarize();
  end
endmodule
`default_nettype wire
